// File: hdl/cmfd_pkg.sv
// package: register map, field layout, reset values and command codes of the command-mode block
`default_nettype none
package cmfd_pkg;
    // register byte offsets on the bus
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_THRESH = 8'h04;
    localparam logic [7:0] OFF_GOOD = 8'h08;
    localparam logic [7:0] OFF_ABORT = 8'h0C;
    localparam logic [7:0] OFF_STATUS = 8'h10;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h14;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h18;
    localparam logic [7:0] OFF_LEVEL = 8'h1C;
    // control register fields
    localparam int CTRL_ECHO_BIT = 0;
    localparam int CTRL_SWFC_BIT = 1;
    localparam int CTRL_INIT_BIT = 2;
    // status register fields
    localparam int STAT_CTS_BIT = 0;
    localparam int STAT_XOFF_BIT = 1;
    localparam int STAT_INIT_BIT = 2;
    // interrupt status fields
    localparam int IRQ_ABORT_BIT = 0;
    localparam int IRQ_GOOD_SAT_BIT = 1;
    localparam int IRQ_OVER_BIT = 2;
    localparam int IRQ_WIDTH = 3;
    // binary command codes
    localparam logic [7:0] CMD_ECHO_OFF = 8'h0A;
    localparam logic [7:0] CMD_ECHO_ON = 8'h0B;
    localparam logic [7:0] CMD_FORCE_INIT = 8'h0D;
    localparam logic [7:0] CMD_SW_FLOW = 8'h07;
    localparam logic [7:0] CMD_THRESH = 8'h24;
    localparam logic [7:0] CMD_GOOD_CNT = 8'h10;
    localparam logic [7:0] CMD_ABORT_CNT = 8'h0F;
    // flow characters and threshold margin
    localparam logic [7:0] CHAR_XON = 8'h11;
    localparam logic [7:0] CHAR_XOFF = 8'h13;
    localparam int THRESH_MARGIN = 'h11;
    // reset values
    localparam logic [15:0] CNT_RESET = 16'h0000;
    localparam logic [15:0] CNT_MAX = 16'hFFFF;
    localparam logic RST_ECHO = 1'b0;
    localparam logic RST_SWFC = 1'b0;
    localparam logic [1:0] HRESP_OKAY = 2'h0;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    typedef enum logic [1:0] {
        CMFD_FC_RUN = 2'b00,
        CMFD_FC_SEND_XOFF = 2'b01,
        CMFD_FC_PAUSED = 2'b10,
        CMFD_FC_SEND_XON = 2'b11
    } cmfd_fc_t;
endpackage : cmfd_pkg
`default_nettype wire

// File: hdl/cmfd_sat_counter.sv
// saturating 16-bit counter with software load
`default_nettype none
module cmfd_sat_counter #(
    parameter int WIDTH = 16
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // control
    input wire logic inc,
    input wire logic load,
    input wire logic [WIDTH-1:0] load_value,
    // state
    output logic [WIDTH-1:0] count,
    output logic saturated
);
    import cmfd_pkg::*;
    logic [WIDTH-1:0] next_count;

    initial begin
        if (WIDTH < 1) $error("cmfd_sat_counter: WIDTH must be positive");
    end

    // load wins over counting; held at all ones rather than wrapping
    always_comb begin
        next_count = count;
        if (load) begin
            next_count = load_value;
        end else if (inc && !saturated) begin
            next_count = count + 1'b1;
        end
    end

    // volatile: every reset returns it to zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

    assign saturated = &count;
endmodule : cmfd_sat_counter
`default_nettype wire

// File: hdl/cmfd_core.sv
// command-mode echo, wake-up initializer, flow control and packet counters behind AHB-Lite
`default_nettype none

// Summary of operation
// [RL1] The echo-off command 0x0A stops text-mode echo, and echo is off after reset.
// [RL2] The echo-on command 0x0B sends every text-mode character back to the host; the core drops one arriving while its one-deep slot is full.
// [RL3] A 16-bit host-accessible counter 0x0F counts packets aborted on a receive error.
// [RL4] The abort counter is cleared on every reset and is held only in volatile flops.
// [RL5] Command 0x0D arms a wake-up initializer for the next transmission without a save.
// [RL6] Setting 0x07 enables software flow control with 1, disables with 0, default 0.
// [RL7] With software flow control, 0x11 resumes and 0x13 pauses the sender.
// [RL8] The device drives clear-to-send to say when the host may send data.
// [RL9] At the threshold fill level clear-to-send drops, or XOFF is sent under software flow; the core drops clear-to-send in both modes.
// [RL10] The threshold accepts 0 up to buffer size minus 0x11 and defaults to that maximum.
// [RL11] A 16-bit host-accessible counter 0x10 counts good packets, default zero.
// [RL12] The good counter is cleared on every reset and is held only in volatile flops.
// [RL13] The good counter saturates at 0xFFFF until written or reset.
module cmfd_core
    import cmfd_pkg::*;
#(
    parameter int BUF_SIZE = 256
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic [1:0] hresp,
    // binary command port from the host parser
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_code,
    input wire logic [15:0] cmd_param,
    input wire logic cmd_write,
    // text command mode characters
    input wire logic text_mode,
    input wire logic text_char_valid,
    input wire logic [7:0] text_char,
    // serial input buffer fill level
    input wire logic [15:0] rx_buf_level,
    // radio packet events
    input wire logic pkt_good,
    input wire logic pkt_abort,
    input wire logic tx_start,
    // serial output byte stream
    output logic tx_byte_valid,
    output logic [7:0] tx_byte,
    input wire logic tx_byte_ready,
    // flow control and radio
    output logic clear_to_send_pin,
    output logic send_initializer,
    // interrupt
    output logic irq
);
    import cmfd_pkg::*;

    localparam logic [15:0] THRESH_MAX = 16'(BUF_SIZE - THRESH_MARGIN);

    initial begin
        if (BUF_SIZE <= THRESH_MARGIN || BUF_SIZE > 65535) $error("cmfd_core: BUF_SIZE out of range");
    end

    ////////////////////////////////////////////////////////////////////////
    // bus address phase capture
    logic wr_pend, next_wr_pend;
    logic [7:0] wr_addr, next_wr_addr;
    logic addr_ok;
    assign addr_ok = hsel && hready && htrans == HTRANS_NONSEQ;

    // write data arrives one cycle after the address, so the address is held
    always_comb begin
        next_wr_pend = addr_ok && hwrite;
        next_wr_addr = addr_ok ? haddr : wr_addr;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
        end else begin
            wr_pend <= next_wr_pend;
            wr_addr <= next_wr_addr;
        end
    end

    // zero wait states, always okay
    assign hreadyout = 1'b1;
    assign hresp = HRESP_OKAY;

    logic bus_wr;
    assign bus_wr = wr_pend;

    ////////////////////////////////////////////////////////////////////////
    // configuration state
    logic echo_en, next_echo_en;
    logic sw_flow_enable, next_sw_flow_enable;
    logic init_armed, next_init_armed;
    logic [15:0] flow_threshold, next_flow_threshold;
    logic [IRQ_WIDTH-1:0] irq_mask, next_irq_mask;
    logic [15:0] new_thresh;
    logic thresh_wr;

    // binary commands and bus writes; a command wins if both land together
    always_comb begin
        next_echo_en = echo_en;
        next_sw_flow_enable = sw_flow_enable;
        next_init_armed = init_armed;
        next_flow_threshold = flow_threshold;
        next_irq_mask = irq_mask;
        new_thresh = flow_threshold;
        thresh_wr = 1'b0;
        // a transmission uses up the arming; arming in the same cycle wins
        if (tx_start) next_init_armed = 1'b0; // [RL5]
        if (bus_wr && wr_addr == OFF_CTRL) begin
            next_echo_en = hwdata[CTRL_ECHO_BIT];
            next_sw_flow_enable = hwdata[CTRL_SWFC_BIT];
            if (hwdata[CTRL_INIT_BIT]) next_init_armed = 1'b1;
        end
        if (bus_wr && wr_addr == OFF_THRESH) begin
            new_thresh = hwdata[15:0];
            thresh_wr = 1'b1;
        end
        if (bus_wr && wr_addr == OFF_IRQ_MASK) next_irq_mask = hwdata[IRQ_WIDTH-1:0];
        if (cmd_valid) begin
            case (cmd_code)
                CMD_ECHO_OFF: next_echo_en = 1'b0; // [RL1]
                CMD_ECHO_ON: next_echo_en = 1'b1; // [RL2]
                CMD_FORCE_INIT: next_init_armed = 1'b1; // [RL5]
                CMD_SW_FLOW: begin
                    if (cmd_write && cmd_param <= 16'h0001) next_sw_flow_enable = cmd_param[0]; // [RL6]
                end
                CMD_THRESH: begin
                    if (cmd_write) begin
                        new_thresh = cmd_param;
                        thresh_wr = 1'b1;
                    end
                end
                default: ;
            endcase
        end
        // values above the limit are refused and the old threshold stays
        if (thresh_wr && new_thresh <= THRESH_MAX) next_flow_threshold = new_thresh; // [RL10]
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            echo_en <= RST_ECHO; // [RL1]
            sw_flow_enable <= RST_SWFC; // [RL6]
            init_armed <= 1'b0;
            flow_threshold <= THRESH_MAX; // [RL10]
            irq_mask <= '0;
        end else begin
            echo_en <= next_echo_en;
            sw_flow_enable <= next_sw_flow_enable;
            init_armed <= next_init_armed;
            flow_threshold <= next_flow_threshold;
            irq_mask <= next_irq_mask;
        end
    end

    // initializer is flagged alongside the transmission that uses it
    assign send_initializer = tx_start && init_armed; // [RL5]

    ////////////////////////////////////////////////////////////////////////
    // packet counters
    logic [15:0] good_count, abort_count;
    logic good_sat, abort_sat;
    logic good_load, abort_load;
    logic [15:0] good_val, abort_val;

    // host sets by command or by bus write
    always_comb begin
        good_load = 1'b0;
        abort_load = 1'b0;
        good_val = cmd_param;
        abort_val = cmd_param;
        if (cmd_valid && cmd_write && cmd_code == CMD_GOOD_CNT) begin
            good_load = 1'b1; // [RL11]
        end else if (bus_wr && wr_addr == OFF_GOOD) begin
            good_load = 1'b1;
            good_val = hwdata[15:0];
        end
        if (cmd_valid && cmd_write && cmd_code == CMD_ABORT_CNT) begin
            abort_load = 1'b1; // [RL3]
        end else if (bus_wr && wr_addr == OFF_ABORT) begin
            abort_load = 1'b1;
            abort_val = hwdata[15:0];
        end
    end

    cmfd_sat_counter #(.WIDTH(16)) u_good (
        .hclk(hclk),
        .hresetn(hresetn),
        .inc(pkt_good),
        .load(good_load),
        .load_value(good_val),
        .count(good_count),
        .saturated(good_sat)
    ); // [RL11] [RL12] [RL13]

    // abort count also stops at full scale; range is 0..0xFFFF
    cmfd_sat_counter #(.WIDTH(16)) u_abort (
        .hclk(hclk),
        .hresetn(hresetn),
        .inc(pkt_abort),
        .load(abort_load),
        .load_value(abort_val),
        .count(abort_count),
        .saturated(abort_sat)
    ); // [RL3] [RL4]

    ////////////////////////////////////////////////////////////////////////
    // flow control: cts level and xon/xoff sequencing
    cmfd_fc_t fc_state, next_fc_state;
    logic over;
    logic fc_byte_req;
    logic [7:0] fc_byte;
    assign over = rx_buf_level >= flow_threshold; // [RL9]

    always_comb begin
        next_fc_state = fc_state;
        fc_byte_req = 1'b0;
        fc_byte = CHAR_XOFF;
        case (fc_state)
            CMFD_FC_RUN: begin
                if (over && sw_flow_enable) next_fc_state = CMFD_FC_SEND_XOFF; // [RL9]
            end
            CMFD_FC_SEND_XOFF: begin
                fc_byte_req = 1'b1;
                fc_byte = CHAR_XOFF; // [RL7]
                if (tx_byte_ready) next_fc_state = CMFD_FC_PAUSED;
            end
            CMFD_FC_PAUSED: begin
                if (!over || !sw_flow_enable) next_fc_state = CMFD_FC_SEND_XON;
            end
            CMFD_FC_SEND_XON: begin
                fc_byte_req = 1'b1;
                fc_byte = CHAR_XON; // [RL7]
                if (tx_byte_ready) next_fc_state = CMFD_FC_RUN;
            end
            default: next_fc_state = CMFD_FC_RUN;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fc_state <= CMFD_FC_RUN;
        end else begin
            fc_state <= next_fc_state;
        end
    end

    // hardware flow stays in force alongside software flow
    logic cts, next_cts;
    always_comb next_cts = !over; // [RL8] [RL9]

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cts <= 1'b1;
        end else begin
            cts <= next_cts;
        end
    end

    assign clear_to_send_pin = cts; // [RL8]

    ////////////////////////////////////////////////////////////////////////
    // echo of text command characters, flow characters take priority
    logic echo_pend, next_echo_pend;
    logic [7:0] echo_char, next_echo_char;

    // one-deep holding slot; a character arriving while full is dropped
    always_comb begin
        next_echo_pend = echo_pend;
        next_echo_char = echo_char;
        if (echo_pend && !fc_byte_req && tx_byte_ready) next_echo_pend = 1'b0;
        if (text_mode && text_char_valid && echo_en && !next_echo_pend) begin
            next_echo_pend = 1'b1; // [RL2]
            next_echo_char = text_char;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            echo_pend <= 1'b0;
            echo_char <= 8'h00;
        end else begin
            echo_pend <= next_echo_pend;
            echo_char <= next_echo_char;
        end
    end

    assign tx_byte_valid = fc_byte_req || echo_pend;
    assign tx_byte = fc_byte_req ? fc_byte : echo_char;

    ////////////////////////////////////////////////////////////////////////
    // interrupt status, write one to clear, set wins
    logic [IRQ_WIDTH-1:0] irq_stat, next_irq_stat, irq_evt;
    always_comb begin
        irq_evt = '0;
        irq_evt[IRQ_ABORT_BIT] = pkt_abort;
        irq_evt[IRQ_GOOD_SAT_BIT] = pkt_good && good_sat;
        irq_evt[IRQ_OVER_BIT] = over && cts;
        next_irq_stat = irq_stat;
        if (bus_wr && wr_addr == OFF_IRQ_STAT) next_irq_stat = irq_stat & ~hwdata[IRQ_WIDTH-1:0];
        next_irq_stat = next_irq_stat | irq_evt;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_stat <= '0;
        end else begin
            irq_stat <= next_irq_stat;
        end
    end

    assign irq = |(irq_stat & irq_mask);

    ////////////////////////////////////////////////////////////////////////
    // read data, registered in the data phase
    logic [31:0] next_hrdata;
    always_comb begin
        next_hrdata = 32'h0000_0000;
        if (addr_ok && !hwrite) begin
            case (haddr)
                OFF_CTRL: begin
                    next_hrdata[CTRL_ECHO_BIT] = echo_en;
                    next_hrdata[CTRL_SWFC_BIT] = sw_flow_enable;
                    next_hrdata[CTRL_INIT_BIT] = init_armed;
                end
                OFF_THRESH: next_hrdata[15:0] = flow_threshold;
                OFF_GOOD: next_hrdata[15:0] = good_count;
                OFF_ABORT: next_hrdata[15:0] = abort_count;
                OFF_STATUS: begin
                    next_hrdata[STAT_CTS_BIT] = cts;
                    next_hrdata[STAT_XOFF_BIT] = fc_state == CMFD_FC_PAUSED;
                    next_hrdata[STAT_INIT_BIT] = init_armed;
                end
                OFF_IRQ_STAT: next_hrdata[IRQ_WIDTH-1:0] = irq_stat;
                OFF_IRQ_MASK: next_hrdata[IRQ_WIDTH-1:0] = irq_mask;
                OFF_LEVEL: next_hrdata[15:0] = rx_buf_level;
                default: next_hrdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else begin
            hrdata <= next_hrdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    a_echo_off_cmd: assert property (@(posedge hclk) disable iff (!hresetn) // [RL1]
        cmd_valid && cmd_code == CMD_ECHO_OFF |=> !echo_en) else $error("echo still on");
    a_echo_char_out: assert property (@(posedge hclk) disable iff (!hresetn) // [RL2]
        text_mode && text_char_valid && echo_en && !echo_pend |=> echo_pend && echo_char == $past(text_char))
        else $error("character not echoed");
    a_abort_count_up: assert property (@(posedge hclk) disable iff (!hresetn) // [RL3]
        pkt_abort && !abort_load && abort_count != CNT_MAX |=> abort_count == $past(abort_count) + 16'h0001)
        else $error("abort count missed");
    a_init_armed: assert property (@(posedge hclk) disable iff (!hresetn) // [RL5]
        cmd_valid && cmd_code == CMD_FORCE_INIT |=> init_armed)
        else $error("initializer not armed");
    a_xoff_sent: assert property (@(posedge hclk) disable iff (!hresetn) // [RL7]
        fc_state == CMFD_FC_SEND_XOFF |-> tx_byte_valid && tx_byte == CHAR_XOFF) else $error("bad xoff");
    a_cts_drops: assert property (@(posedge hclk) disable iff (!hresetn) // [RL9]
        rx_buf_level >= flow_threshold |=> !clear_to_send_pin) else $error("cts not dropped");
    a_thresh_limit: assert property (@(posedge hclk) disable iff (!hresetn) // [RL10]
        flow_threshold <= THRESH_MAX) else $error("threshold above limit");
    a_good_sat_hold: assert property (@(posedge hclk) disable iff (!hresetn) // [RL13]
        good_count == CNT_MAX && !good_load |=> good_count == CNT_MAX) else $error("good count wrapped");
    a_good_count_up: assert property (@(posedge hclk) disable iff (!hresetn) // [RL11]
        pkt_good && !good_load && !good_sat |=> good_count == $past(good_count) + 16'h0001)
        else $error("good count missed");
endmodule : cmfd_core
`default_nettype wire

// File: sim/cmfd_host_model.sv
// host controller model on the serial side: stalls, fills the input buffer, obeys flow control
`default_nettype none
module cmfd_host_model (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // byte stream from the device
    input wire logic tx_byte_valid,
    input wire logic [7:0] tx_byte,
    output logic tx_byte_ready,
    // flow control and buffer
    input wire logic clear_to_send_pin,
    input wire logic send_en,
    input wire logic drain,
    output logic [15:0] rx_buf_level,
    // received byte report
    output logic got_valid,
    output logic [7:0] got_byte
);
    timeunit 1ns;
    timeprecision 1ps;
    logic paused;
    logic [1:0] tick;
    int seed = 32'h7abd7ea7;
    int rnd;
    // random stalls, never more than three cycles long, so waits stay bounded
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tick <= 2'h0;
            tx_byte_ready <= 1'b0;
            paused <= 1'b0;
            rx_buf_level <= 16'h0000;
            got_valid <= 1'b0;
            got_byte <= 8'h00;
        end else begin
            rnd = $random(seed);
            tick <= tick + 2'h1;
            tx_byte_ready <= (tick == 2'h2) || rnd[0];
            got_valid <= tx_byte_valid && tx_byte_ready;
            got_byte <= tx_byte;
            if (tx_byte_valid && tx_byte_ready && tx_byte == 8'h13) paused <= 1'b1;
            if (tx_byte_valid && tx_byte_ready && tx_byte == 8'h11) paused <= 1'b0;
            // one byte a cycle, only while clear-to-send allows and not paused
            if (send_en && clear_to_send_pin && !paused) rx_buf_level <= rx_buf_level + 16'h0001;
            else if (drain && rx_buf_level != 16'h0000) rx_buf_level <= rx_buf_level - 16'h0001;
        end
    end
endmodule : cmfd_host_model
`default_nettype wire

// File: sim/cmfd_core_tb.sv
// self-checking testbench of the command-mode block
`default_nettype none
module cmfd_core_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import cmfd_pkg::*;
    localparam int BUF = 64;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0, hwrite = 1'b0, hreadyout, cmd_valid = 1'b0, cmd_write = 1'b0;
    logic [7:0] haddr = 8'h00, cmd_code = 8'h00, text_char = 8'h00, tx_byte, got_byte;
    logic [1:0] htrans = 2'h0, hresp;
    logic [31:0] hwdata = 32'h0, hrdata, v;
    logic [15:0] cmd_param = 16'h0000, rx_buf_level;
    logic text_mode = 1'b1, text_char_valid = 1'b0, pkt_good = 1'b0, pkt_abort = 1'b0, tx_start = 1'b0;
    logic tx_byte_valid, tx_byte_ready, clear_to_send_pin, send_initializer, irq;
    logic send_en = 1'b0, drain = 1'b0, got_valid;
    int fail_count = 0, tests_run = 0, cycles = 0, seed = 32'h7abd7ea7, n, i;
    logic [7:0] exp_q[$], got_q[$];
    cmfd_core #(.BUF_SIZE(BUF)) u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_param(cmd_param),
        .cmd_write(cmd_write), .text_mode(text_mode), .text_char_valid(text_char_valid), .text_char(text_char),
        .rx_buf_level(rx_buf_level), .pkt_good(pkt_good), .pkt_abort(pkt_abort), .tx_start(tx_start),
        .tx_byte_valid(tx_byte_valid), .tx_byte(tx_byte), .tx_byte_ready(tx_byte_ready),
        .clear_to_send_pin(clear_to_send_pin), .send_initializer(send_initializer), .irq(irq));
    cmfd_host_model u_host (.hclk(hclk), .hresetn(hresetn), .tx_byte_valid(tx_byte_valid), .tx_byte(tx_byte),
        .tx_byte_ready(tx_byte_ready), .clear_to_send_pin(clear_to_send_pin), .send_en(send_en), .drain(drain),
        .rx_buf_level(rx_buf_level), .got_valid(got_valid), .got_byte(got_byte));
    always #2.5 hclk = ~hclk;
    // collect bytes the host received
    always @(negedge hclk) begin
        if (got_valid === 1'b1) got_q.push_back(got_byte);
    end
    // hang guard
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            report_and_stop();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : report_and_stop
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // one single AHB-Lite word transfer, zero or more wait states
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= HTRANS_NONSEQ;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        check({30'h0, hresp}, 32'h0);
    endtask : ahb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        ahb(1'b1, a, d, x);
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] x;
        ahb(1'b0, a, 32'h0, x);
        check(x, exp);
    endtask : rdc
    task automatic cmd(input logic [7:0] c, input logic [15:0] p);
        @(posedge hclk);
        cmd_valid <= 1'b1;
        cmd_write <= 1'b1;
        cmd_code <= c;
        cmd_param <= p;
        @(posedge hclk);
        cmd_valid <= 1'b0;
    endtask : cmd
    // one typed character, expected back only with echo on in text mode
    task automatic type_char(input logic echo, input logic tm);
        @(posedge hclk);
        text_mode <= tm;
        text_char_valid <= 1'b1;
        text_char <= 8'($random(seed)) | 8'h20;
        @(posedge hclk);
        text_char_valid <= 1'b0;
        if (echo && tm) exp_q.push_back(text_char);
        repeat (12) @(posedge hclk);
    endtask : type_char
    task automatic cmp_q();
        check(got_q.size(), exp_q.size());
        foreach (exp_q[k]) if (k < got_q.size()) check(got_q[k], exp_q[k]);
        got_q = {};
        exp_q = {};
    endtask : cmp_q
    task automatic start_tx(input logic exp);
        logic s;
        @(posedge hclk);
        tx_start <= 1'b1;
        @(negedge hclk);
        s = send_initializer;
        @(posedge hclk);
        tx_start <= 1'b0;
        check(s, exp);
    endtask : start_tx
    // level sweep: fill until flow control stops the host, then drain to empty
    task automatic fill_drain();
        send_en <= 1'b1;
        for (i = 0; i < 200 && clear_to_send_pin === 1'b1; i++) @(posedge hclk);
        repeat (4) @(posedge hclk);
        send_en <= 1'b0;
        repeat (3) @(negedge hclk);
        check(clear_to_send_pin, 1'b0);
        drain <= 1'b1;
        for (i = 0; i < 200 && rx_buf_level !== 16'h0000; i++) @(posedge hclk);
        drain <= 1'b0;
        repeat (20) @(negedge hclk);
        check(clear_to_send_pin, 1'b1);
    endtask : fill_drain
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        rdc(OFF_CTRL, 32'h0);
        rdc(OFF_THRESH, BUF - THRESH_MARGIN);
        rdc(OFF_GOOD, 32'h0);
        rdc(OFF_ABORT, 32'h0);
        // echo: default off, on for text mode only, then off again
        type_char(1'b0, 1'b1);
        cmd(CMD_ECHO_ON, 16'h0000);
        for (n = 0; n < 4; n++) type_char(1'b1, n != 2);
        cmd(CMD_ECHO_OFF, 16'h0000);
        type_char(1'b0, 1'b1);
        cmp_q();
        // threshold limits: one above the top is refused
        wr(OFF_THRESH, BUF - THRESH_MARGIN + 1);
        rdc(OFF_THRESH, BUF - THRESH_MARGIN);
        wr(OFF_THRESH, 32'h0);
        rdc(OFF_THRESH, 32'h0);
        cmd(CMD_THRESH, 16'd10);
        rdc(OFF_THRESH, 32'd10);
        fill_drain();
        cmp_q();
        // software flow: XOFF at the threshold, XON once drained
        cmd(CMD_SW_FLOW, 16'h0001);
        cmd(CMD_SW_FLOW, 16'h0002);
        rdc(OFF_CTRL, 32'h2);
        fill_drain();
        exp_q = {CHAR_XOFF, CHAR_XON};
        cmp_q();
        cmd(CMD_SW_FLOW, 16'h0000);
        rdc(OFF_CTRL, 32'h0);
        // good counter: random run, saturation, reload
        n = ($random(seed) & 7) + 1;
        @(posedge hclk) pkt_good <= 1'b1;
        repeat (n) @(posedge hclk);
        pkt_good <= 1'b0;
        rdc(OFF_GOOD, n);
        cmd(CMD_GOOD_CNT, 16'hFFFD);
        @(posedge hclk) pkt_good <= 1'b1;
        repeat (5) @(posedge hclk);
        pkt_good <= 1'b0;
        rdc(OFF_GOOD, 32'hFFFF);
        wr(OFF_GOOD, 32'h5);
        rdc(OFF_GOOD, 32'h5);
        // abort counter and its interrupt: set, mask, clear
        wr(OFF_IRQ_STAT, 32'h7);
        n = ($random(seed) & 7) + 2;
        @(posedge hclk) pkt_abort <= 1'b1;
        repeat (n) @(posedge hclk);
        pkt_abort <= 1'b0;
        rdc(OFF_ABORT, n);
        wr(OFF_ABORT, 32'h1234);
        rdc(OFF_ABORT, 32'h1234);
        rdc(OFF_IRQ_STAT, 32'h1);
        wr(OFF_IRQ_MASK, 32'h0);
        @(negedge hclk) check(irq, 1'b0);
        wr(OFF_IRQ_MASK, 32'h7);
        @(negedge hclk) check(irq, 1'b1);
        wr(OFF_IRQ_STAT, 32'h7);
        rdc(OFF_IRQ_STAT, 32'h0);
        check(irq, 1'b0);
        wr(OFF_IRQ_MASK, 32'h0);
        @(negedge hclk) check(irq, 1'b0);
        // initializer armed by command or register, used by one transmission
        for (n = 0; n < 2; n++) begin
            if (n == 0) cmd(CMD_FORCE_INIT, 16'h0000);
            else wr(OFF_CTRL, 32'h4);
            ahb(1'b0, OFF_STATUS, 32'h0, v);
            check(v[STAT_INIT_BIT], 1'b1);
            start_tx(1'b1);
            start_tx(1'b0);
        end
        // second reset in mid-run clears both counters
        @(posedge hclk) hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        rdc(OFF_GOOD, 32'h0);
        rdc(OFF_ABORT, 32'h0);
        rdc(OFF_CTRL, 32'h0);
        report_and_stop();
    end
endmodule : cmfd_core_tb
`default_nettype wire
